//--- common/lvd_pkg.sv
package lvd_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_LEVEL = 8'h04;
	localparam logic [7:0] ADDR_IRQF  = 8'h08;
	localparam logic [7:0] ADDR_MASK  = 8'h0c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_FLAG   = 0;
	localparam int BIT_ACTION = 1;
	localparam int BIT_SOURCE = 2;
	localparam int BIT_ON     = 7;
	localparam int BIT_IRQ    = 0;
	localparam int LEVEL_W    = 4;

	// ----------------------------------------------------------------
	// reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic       MASK_RST   = 1'b1;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ     = 50;
	localparam int SETTLE_US   = 10;
	localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;

	typedef enum logic [1:0] {
		LVD_WR_IDLE = 2'b00,
		LVD_WR_RESP = 2'b01
	} lvd_wr_e;

endpackage

//--- common/lvd_cmp_if.sv
`timescale 1ns/1ps
interface lvd_cmp_if;
	logic raw;
	logic level_ok;
	logic rise;
	logic fall;
	modport sync_side (input raw, output level_ok, output rise, output fall);
	modport core_side (output raw, input level_ok, input rise, input fall);
endinterface

//--- rtl/lvd_sync.sv
`timescale 1ns/1ps
module lvd_sync
	import lvd_pkg::*;
(
	input  wire logic      clk_sys_i,
	input  wire logic      rst_b_i,
	input  wire logic      enable_i,
	lvd_cmp_if.sync_side   cmp
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} lvd_sync_s;

	lvd_sync_s st;
	lvd_sync_s next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = cmp.raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (!enable_i) begin
			next_st.s3 = st.s2;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// only s2/s3 are looked at; s1 may be metastable
	assign cmp.level_ok = st.s2;
	assign cmp.rise     = enable_i && st.s2 && !st.s3;
	assign cmp.fall     = enable_i && !st.s2 && st.s3;
endmodule

//--- rtl/lvd_ctrl.sv
// Notes on behaviour
// - any reset sets interrupt mask to 1
// - interrupt mode: crossing raises request flag
// - control bit 7 enables, clearing stops
// - control bit 0 shows level at/above threshold (here it reads 0 while bit 7 is clear)
// - control bit 1: 0 interrupt, 1 reset
// - request flag is bit 0 of flag register
// - source select picks fixed external threshold
// - reset mode: reset while level below
// - level register bits 3:0 pick threshold
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lvd_ctrl
	import lvd_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        supply_cmp_i,
	input  wire logic        ext_cmp_i,
	output logic             detector_on_o,
	output logic             source_select_o,
	output logic [3:0]       level_select_o,
	output logic             detect_irq_o,
	output logic             internal_reset_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic               detector_on;
		logic               source_select;
		logic               action_select;
		logic [LEVEL_W-1:0] level_select;
		logic               detect_irq_request;
		logic               detect_irq_mask;
		logic               rst_req;
		logic               aw_held;
		logic [7:0]         aw_addr;
		logic               w_held;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} lvd_ctrl_s;

	lvd_ctrl_s st;
	lvd_ctrl_s next_st;
	lvd_cmp_if cmp ();

	// external pin uses its own fixed reference, so the level select is ignored there
	assign cmp.raw = st.source_select ? ext_cmp_i : supply_cmp_i;

	lvd_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.enable_i  (st.detector_on),
		.cmp       (cmp)
	);

	function automatic logic [31:0] ctrl_word(input lvd_ctrl_s s, input logic lvl);
		logic [31:0] w;
		w             = 32'h0000_0000;
		w[BIT_ON]     = s.detector_on;
		w[BIT_SOURCE] = s.source_select;
		w[BIT_ACTION] = s.action_select;
		w[BIT_FLAG]   = s.detector_on & lvl;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic        irq_set;
	logic [31:0] wd;
	logic        wl;

	always_comb begin
		next_st  = st;
		wd       = st.w_data;
		wl       = st.w_strb[0];
		irq_set  = 1'b0;

		// capture write address and data in either order
		if (s_axi_awvalid && !st.aw_held && !st.bvalid) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held && !st.bvalid) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end

		// crossing in interrupt mode raises the request
		if (st.detector_on && !st.action_select && (cmp.rise || cmp.fall)) begin
			irq_set = 1'b1;
		end

		if (st.aw_held && st.w_held) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = RESP_OKAY;
			if (st.aw_addr == ADDR_CTRL) begin
				if (wl) begin
					// a zero byte clears every control bit together
					next_st.detector_on   = wd[BIT_ON];
					next_st.source_select = wd[BIT_SOURCE];
					next_st.action_select = wd[BIT_ACTION];
				end
			end else if (st.aw_addr == ADDR_LEVEL) begin
				if (wl) begin
					next_st.level_select = wd[LEVEL_W-1:0];
				end
			end else if (st.aw_addr == ADDR_IRQF) begin
				if (wl && wd[BIT_IRQ]) begin
					next_st.detect_irq_request = 1'b0;
				end
			end else if (st.aw_addr == ADDR_MASK) begin
				if (wl) begin
					next_st.detect_irq_mask = wd[BIT_IRQ];
				end
			end else begin
				next_st.bresp = RESP_SLVERR;
			end
		end
		// set wins over a simultaneous clear
		if (irq_set) begin
			next_st.detect_irq_request = 1'b1;
		end

		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			if (s_axi_araddr == ADDR_CTRL) begin
				next_st.rdata = ctrl_word(st, cmp.level_ok);
			end else if (s_axi_araddr == ADDR_LEVEL) begin
				next_st.rdata = {{(32-LEVEL_W){1'b0}}, st.level_select};
			end else if (s_axi_araddr == ADDR_IRQF) begin
				next_st.rdata = {31'h0000_0000, st.detect_irq_request};
			end else if (s_axi_araddr == ADDR_MASK) begin
				next_st.rdata = {31'h0000_0000, st.detect_irq_mask};
			end else begin
				next_st.rdata = 32'h0000_0000;
				next_st.rresp = RESP_SLVERR;
			end
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// reset mode holds reset while the synchronised level is low
		next_st.rst_req = next_st.detector_on && next_st.action_select && !cmp.level_ok;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			st                 <= '0;
			st.detect_irq_mask <= MASK_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready    = !st.aw_held && !st.bvalid;
	assign s_axi_wready     = !st.w_held && !st.bvalid;
	assign s_axi_bvalid     = st.bvalid;
	assign s_axi_bresp      = st.bresp;
	assign s_axi_arready    = !st.rvalid;
	assign s_axi_rvalid     = st.rvalid;
	assign s_axi_rdata      = st.rdata;
	assign s_axi_rresp      = st.rresp;
	assign detector_on_o    = st.detector_on;
	assign source_select_o  = st.source_select;
	assign level_select_o   = st.level_select;
	assign detect_irq_o     = st.detect_irq_request && !st.detect_irq_mask;
	assign internal_reset_o = st.rst_req;
endmodule

//--- tb/lvd_ctrl_monitor.sv
`timescale 1ns/1ps
module lvd_ctrl_monitor (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        supply_cmp_i,
	input wire logic        ext_cmp_i,
	input wire logic        detector_on_o,
	input wire logic        source_select_o,
	input wire logic        detect_irq_o,
	input wire logic        internal_reset_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// five cycles covers two sync flops plus the output register
	sequence lvl_high_s;
		(detector_on_o && (source_select_o ? ext_cmp_i : supply_cmp_i)) [*5];
	endsequence
	mask_after_rst_a: assert property ($rose(rst_b_i) |-> !detect_irq_o)
		else $error("irq high after reset");
	rst_release_a: assert property (lvl_high_s |-> !internal_reset_o)
		else $error("reset held with level high");
	rst_needs_on_a: assert property (internal_reset_o |-> detector_on_o || $past(detector_on_o))
		else $error("reset while detector off");
	on_by_write_a: assert property ($changed(detector_on_o) && $past(rst_b_i) |-> ##[0:2] s_axi_bvalid)
		else $error("enable changed without write");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
endmodule

//--- tb/test_lvd_ctrl.sv
`timescale 1ns/1ps
module test_lvd_ctrl;
	import lvd_pkg::*;
	logic        clk_sys_i, rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_cmp_i, ext_cmp_i;
	logic        detector_on_o, source_select_o, detect_irq_o, internal_reset_o;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, level_select_o;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          miscompares, comparisons, cycles;
	lvd_ctrl i_lvd_ctrl (.clk_sys_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_cmp_i,
		.ext_cmp_i, .detector_on_o, .source_select_o, .level_select_o, .detect_irq_o, .internal_reset_o);
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chkb(input string n, input logic e, input logic s);
		chk(n, {31'h0, e}, {31'h0, s});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, input string n);
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(n, e, s_axi_rdata);
		chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rst_b_i} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, supply_cmp_i, ext_cmp_i, cycles} = 0;
		s_axi_wstrb = 4'hf;
		tick(16);
		rst_b_i <= 1'b1;
		rd(ADDR_MASK, 32'h1, RESP_OKAY, "mask");
		rd(ADDR_CTRL, 32'h0, RESP_OKAY, "ctrl");
		rd(8'h10, 32'h0, RESP_SLVERR, "unmapped");
		wr(ADDR_LEVEL, 32'hf);
		chk("level", 32'hf, {28'h0, level_select_o});
		rd(ADDR_LEVEL, 32'hf, RESP_OKAY, "level");
		$display("test regs done");
		ext_cmp_i <= 1'b1;
		wr(ADDR_CTRL, 32'h84);
		tick(SETTLE_CYC);
		chkb("src", 1'b1, source_select_o);
		rd(ADDR_CTRL, 32'h85, RESP_OKAY, "ext flag");
		supply_cmp_i <= 1'b1;
		ext_cmp_i <= 1'b0;
		wr(ADDR_CTRL, 32'h80);
		tick(4);
		chkb("on", 1'b1, detector_on_o);
		wr(ADDR_IRQF, 32'h1);
		wr(ADDR_MASK, 32'h0);
		tick(2);
		chkb("irq idle", 1'b0, detect_irq_o);
		supply_cmp_i <= 1'b0;
		tick(4);
		chkb("irq fall", 1'b1, detect_irq_o);
		rd(ADDR_IRQF, 32'h1, RESP_OKAY, "request");
		rd(ADDR_CTRL, 32'h80, RESP_OKAY, "flag low");
		wr(ADDR_IRQF, 32'h1);
		tick(2);
		chkb("irq clr", 1'b0, detect_irq_o);
		supply_cmp_i <= 1'b1;
		tick(4);
		chkb("irq rise", 1'b1, detect_irq_o);
		wr(ADDR_MASK, 32'h1);
		tick(2);
		chkb("irq mask", 1'b0, detect_irq_o);
		wr(ADDR_CTRL, 32'h0);
		tick(2);
		chkb("bit stop", 1'b0, detector_on_o);
		$display("test irq done");
		wr(ADDR_IRQF, 32'h1);
		wr(ADDR_CTRL, 32'h82);
		supply_cmp_i <= 1'b0;
		tick(4);
		chkb("rst", 1'b1, internal_reset_o);
		rd(ADDR_IRQF, 32'h0, RESP_OKAY, "no request");
		supply_cmp_i <= 1'b1;
		tick(4);
		chkb("rst off", 1'b0, internal_reset_o);
		wr(ADDR_CTRL, 32'h0);
		tick(2);
		chkb("stop", 1'b0, detector_on_o);
		rd(ADDR_CTRL, 32'h0, RESP_OKAY, "ctrl stop");
		wr(ADDR_MASK, 32'h0);
		rst_b_i <= 1'b0;
		tick(2);
		rst_b_i <= 1'b1;
		rd(ADDR_MASK, 32'h1, RESP_OKAY, "mask again");
		chk("level rst", 32'h0, {28'h0, level_select_o});
		$display("test modes done");
		wrap_up();
	end
endmodule
bind lvd_ctrl lvd_ctrl_monitor i_lvd_ctrl_monitor (.clk_sys_i, .rst_b_i, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .supply_cmp_i, .ext_cmp_i,
	.detector_on_o, .source_select_o, .detect_irq_o, .internal_reset_o);
